// ==== hw/bt_wdt_pkg.sv ====
package bt_wdt_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_BASIC_TIMER_CONTROL = 8'hD3;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hFC;
  localparam logic [7:0] ADDR_BASIC_TIMER_COUNT = 8'hFD;

  // ****************************************************************
  // Field layout and values
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;  // Reset value of control.
  localparam int SEL_LO = 2;                  // Clock select field [3:2].
  localparam int SEL_HI = 3;
  localparam int CNT_CLR_BIT = 1;             // Counter clear strobe.
  localparam int DIV_CLR_BIT = 0;             // Divider clear strobe.
  localparam logic [3:0] KEY_CODE = 4'hA;     // Disable / clear key 1010.
  localparam logic [7:0] COUNT_ZERO = 8'h00;  // Cleared counter value.
  localparam logic [7:0] COUNT_TOP = 8'hFF;   // Last value before wrap.
  localparam logic [7:0] COUNT_STEP = 8'h01;  // Counter increment.
  localparam int KEY_LO = 4;                  // Key field [7:4].
  localparam int KEY_HI = 7;
  localparam int CLR_LO = 0;                  // Clear code field [3:0].
  localparam int CLR_HI = 3;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;  // Reset and read-back nibble.

  // ****************************************************************
  // Prescaler: one divider, taps chosen by the select field
  // ****************************************************************
  localparam int DIV_W = 12;                  // Covers divide by 4096.
  localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;
  localparam logic [DIV_W-1:0] DIV_STEP = 12'h001;
  localparam logic [1:0] SEL_4096 = 2'h0;     // Select field encodings.
  localparam logic [1:0] SEL_1024 = 2'h1;
  localparam logic [1:0] SEL_128 = 2'h2;
  localparam logic [1:0] SEL_16 = 2'h3;
  localparam logic [DIV_W-1:0] MASK_4096 = 12'hFFF;
  localparam logic [DIV_W-1:0] MASK_1024 = 12'h3FF;
  localparam logic [DIV_W-1:0] MASK_128 = 12'h07F;
  localparam logic [DIV_W-1:0] MASK_16 = 12'h00F;

  // Low bits that must all be one for a carry out of a given bit.
  localparam logic [7:0] CARRY_BIT3 = 8'h0F;  // Watchdog, timer source.
  localparam logic [7:0] CARRY_BIT4 = 8'h1F;  // Stabilization interval.
  localparam logic [7:0] CARRY_BIT7 = 8'hFF;  // Watchdog, ring source.

  // Register port request, one per cycle.
  typedef struct packed {
    logic       wr;     // Write strobe.
    logic       rd;     // Read strobe.
    logic [7:0] addr;   // Register address.
    logic [7:0] wdata;  // Write data.
  } reg_req_s;

  // Power-up phase of the block.
  typedef enum logic [1:0] {
    PH_START,   // First cycle after reset release.
    PH_STAB,    // Oscillator stabilization, processor held.
    PH_RUN      // Normal operation.
  } phase_e;

endpackage

// ==== hw/basic_timer_watchdog.sv ====
`timescale 1ns/10ps
module basic_timer_watchdog
  import bt_wdt_pkg::*;
(
  input wire logic i_sys_clk,          // System clock, 10 MHz.
  input wire logic i_rst_n,            // Synchronous reset, active low.
  input wire reg_req_s i_reg,          // Register access request.
  input wire logic i_power_on,         // Last reset was a power-on reset.
  input wire logic i_opt_ring_src,     // One-time option: ring clocks wdt.
  input wire logic i_ring_tick,        // One pulse per ring osc period.
  input wire logic i_stop_idle,        // Core is in stop or idle mode.
  output logic [7:0] o_reg_rdata,      // Read data, one cycle after rd.
  output logic o_wdt_reset,            // One-cycle system reset request.
  output logic o_cpu_hold,             // Processor held idle.
  output logic o_tc_div_clr,           // Clear pulse to timer/counter div.
  output logic o_ring_osc_en,          // Ring oscillator run enable.
  output logic o_basic_overflow_pulse  // Basic counter wrap pulse.
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] ctrl_ff, nxt_ctrl;            // Control, strobe bits zero.
  logic [3:0] wd_key_ff, nxt_wd_key;        // Watchdog ctrl upper nibble.
  logic [DIV_W-1:0] div_ff, nxt_div;        // Prescaler divider.
  logic [7:0] count_ff, nxt_count;          // Basic timer counter.
  logic [7:0] wd_count_ff, nxt_wd_count;    // Watchdog counter.
  logic stop_ff, nxt_stop;                  // Previous stop/idle level.
  phase_e phase_ff, nxt_phase;              // Power-up phase.
  logic [7:0] rdata_ff, nxt_rdata;          // Read data register.
  logic wdt_rst_ff, nxt_wdt_rst;            // Reset request register.
  logic tc_clr_ff, nxt_tc_clr;              // Divider clear pulse.
  logic ring_en_ff, nxt_ring_en;            // Ring oscillator enable.
  logic ovf_ff, nxt_ovf;                    // Overflow pulse register.
  logic hold_ff, nxt_hold;                  // Processor hold register.

  // Decoded register strobes and per-cycle timer events.
  logic wr_ctrl;      // Write to control register.
  logic wr_wd;        // Write to watchdog control register.
  logic div_tick;     // Selected divided-clock tick.
  logic bt_ovf;       // Basic counter wraps this cycle.
  logic wd_tick;      // Watchdog counter advances this cycle.
  logic wd_clear;     // Watchdog counter cleared this cycle.
  logic wd_ovf;       // Watchdog overflow this cycle.
  logic ring_stop;    // Ring oscillator is to be stopped.
  logic cnt_clr;      // Counter clear strobe written this cycle.

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // True when an increment carries out of the bit that the mask covers.
  function automatic logic carries(input logic [7:0] value,
                                   input logic [7:0] mask);
    carries = ((value & mask) == mask);
  endfunction

  // Divider tick for the chosen ratio; all low taps one means wrap.
  function automatic logic tap_hit(input logic [DIV_W-1:0] div,
                                   input logic [1:0] sel);
    logic [DIV_W-1:0] mask;
    mask = MASK_4096;
    case (sel)
      SEL_4096: mask = MASK_4096;
      SEL_1024: mask = MASK_1024;
      SEL_128: mask = MASK_128;
      SEL_16: mask = MASK_16;
      default: mask = MASK_4096;
    endcase
    tap_hit = ((div & mask) == mask);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Everything lives in one group: the counters depend on register
  // writes in the same cycle, so splitting would only add wiring.
  always_comb begin
    wr_ctrl = i_reg.wr && (i_reg.addr == ADDR_BASIC_TIMER_CONTROL);
    wr_wd = i_reg.wr && (i_reg.addr == ADDR_WATCHDOG_CONTROL);

    // Control register; the two strobe bits never store.
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = i_reg.wdata;
      nxt_ctrl[CNT_CLR_BIT] = 1'b0;
      nxt_ctrl[DIV_CLR_BIT] = 1'b0;
    end

    // Only the upper nibble stores; the clear nibble reads as zero.
    nxt_wd_key = wd_key_ff;
    if (wr_wd) begin
      nxt_wd_key = i_reg.wdata[KEY_HI:KEY_LO];
    end

    // Prescaler runs freely and is cleared by the divider strobe.
    div_tick = tap_hit(div_ff, ctrl_ff[SEL_HI:SEL_LO]);
    nxt_div = div_ff + DIV_STEP;
    nxt_tc_clr = 1'b0;
    if (wr_ctrl && i_reg.wdata[DIV_CLR_BIT]) begin
      nxt_div = DIV_ZERO;
      nxt_tc_clr = 1'b1;
    end

    // Basic counter; a clear write wins over a tick in the same cycle,
    // and then no wrap is reported, since the counter never wrapped.
    cnt_clr = wr_ctrl && i_reg.wdata[CNT_CLR_BIT];
    bt_ovf = div_tick && (count_ff == COUNT_TOP) && !cnt_clr;
    nxt_count = count_ff;
    if (div_tick) begin
      nxt_count = count_ff + COUNT_STEP;
    end
    if (cnt_clr) begin
      nxt_count = COUNT_ZERO;
    end
    nxt_ovf = bt_ovf;

    // Ring oscillator stops in low-power modes only under the key.
    ring_stop = i_opt_ring_src && (wd_key_ff == KEY_CODE)
                && i_stop_idle;
    nxt_ring_en = !ring_stop;
    nxt_stop = i_stop_idle;

    // Watchdog clock source and overflow point come from the option.
    wd_tick = i_opt_ring_src ? (i_ring_tick && ring_en_ff)
                             : bt_ovf;
    wd_ovf = wd_tick && (i_opt_ring_src ? carries(wd_count_ff, CARRY_BIT7)
                                        : carries(wd_count_ff, CARRY_BIT3));
    wd_clear = cnt_clr
               || (wr_wd
                   && (i_reg.wdata[CLR_HI:CLR_LO] == KEY_CODE))
               || (ring_stop && !stop_ff);
    nxt_wd_count = wd_count_ff;
    if (wd_ovf) begin
      nxt_wd_count = COUNT_ZERO;
    end else if (wd_tick) begin
      nxt_wd_count = wd_count_ff + COUNT_STEP;
    end
    if (wd_clear) begin
      nxt_wd_count = COUNT_ZERO;
    end

    // Reset request only while the watchdog is enabled.
    nxt_wdt_rst = wd_ovf && !wd_clear
                  && (ctrl_ff[KEY_HI:KEY_LO] != KEY_CODE);

    // Power-up phase: the power-on flag is sampled after release.
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_START: begin
        nxt_phase = i_power_on ? PH_STAB : PH_RUN;
      end
      PH_STAB: begin
        if (div_tick && carries(count_ff, CARRY_BIT4)) begin
          nxt_phase = PH_RUN;
        end
      end
      PH_RUN: begin
        nxt_phase = PH_RUN;
      end
      default: begin
        nxt_phase = PH_RUN;
      end
    endcase

    // Hold is registered so the core sees a clean level from a flop.
    nxt_hold = (nxt_phase != PH_RUN);

    // Read data; unmapped addresses read zero.
    nxt_rdata = rdata_ff;
    if (i_reg.rd) begin
      case (i_reg.addr)
        ADDR_BASIC_TIMER_CONTROL: nxt_rdata = ctrl_ff;
        ADDR_WATCHDOG_CONTROL: nxt_rdata = {wd_key_ff, NIBBLE_ZERO};
        ADDR_BASIC_TIMER_COUNT: nxt_rdata = count_ff;
        default: nxt_rdata = COUNT_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // The hold starts asserted in reset so the core never runs on an
  // unsettled oscillator before the power-on flag has been sampled.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_ff <= CTRL_RESET;
      wd_key_ff <= NIBBLE_ZERO;
      div_ff <= DIV_ZERO;
      count_ff <= COUNT_ZERO;
      wd_count_ff <= COUNT_ZERO;
      stop_ff <= 1'b0;
      phase_ff <= PH_START;
      rdata_ff <= COUNT_ZERO;
      wdt_rst_ff <= 1'b0;
      tc_clr_ff <= 1'b0;
      ring_en_ff <= 1'b1;
      ovf_ff <= 1'b0;
      hold_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      wd_key_ff <= nxt_wd_key;
      div_ff <= nxt_div;
      count_ff <= nxt_count;
      wd_count_ff <= nxt_wd_count;
      stop_ff <= nxt_stop;
      phase_ff <= nxt_phase;
      rdata_ff <= nxt_rdata;
      wdt_rst_ff <= nxt_wdt_rst;
      tc_clr_ff <= nxt_tc_clr;
      ring_en_ff <= nxt_ring_en;
      ovf_ff <= nxt_ovf;
      hold_ff <= nxt_hold;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_reg_rdata = rdata_ff;
  assign o_wdt_reset = wdt_rst_ff;
  assign o_cpu_hold = hold_ff;
  assign o_tc_div_clr = tc_clr_ff;
  assign o_ring_osc_en = ring_en_ff;
  assign o_basic_overflow_pulse = ovf_ff;

endmodule

// ==== dv/basic_timer_watchdog_chk.sv ====
`timescale 1ns/10ps
module basic_timer_watchdog_chk
  import bt_wdt_pkg::*;
(
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rst_n, // Reset, low.
  input wire reg_req_s i_reg, // Request.
  input wire logic i_power_on, // Power-on flag.
  input wire logic i_opt_ring_src, // Ring option.
  input wire logic i_ring_tick, // Ring tick.
  input wire logic i_stop_idle, // Stop or idle.
  input wire logic [7:0] o_reg_rdata, // Read data.
  input wire logic o_wdt_reset, // Reset request.
  input wire logic o_cpu_hold, // Processor hold.
  input wire logic o_tc_div_clr, // Divider clear.
  input wire logic o_ring_osc_en, // Ring enable.
  input wire logic o_basic_overflow_pulse // Wrap pulse.
);
  // ****
  // Key shadows
  // ****
  wire logic wr_ctl = i_reg.wr && i_reg.addr == ADDR_BASIC_TIMER_CONTROL;
  wire logic wr_wdc = i_reg.wr && i_reg.addr == ADDR_WATCHDOG_CONTROL;
  wire logic rd_bad = i_reg.rd && !(i_reg.addr inside
    {ADDR_BASIC_TIMER_CONTROL, ADDR_WATCHDOG_CONTROL, ADDR_BASIC_TIMER_COUNT});
  logic [3:0] bkey_ff; // Control upper nibble.
  logic [3:0] wkey_ff; // Watchdog control upper nibble.
  // Shadows follow writes, since the checker cannot look inside.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bkey_ff <= 4'h0;
      wkey_ff <= 4'h0;
    end else begin
      if (wr_ctl) bkey_ff <= i_reg.wdata[7:4];
      if (wr_wdc) wkey_ff <= i_reg.wdata[7:4];
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_div_clr;
    wr_ctl && i_reg.wdata[DIV_CLR_BIT];
  endsequence
  sequence s_kick;
    wr_wdc && i_reg.wdata[3:0] == KEY_CODE;
  endsequence
  a_div_clr_pulse: assert property (s_div_clr |=> o_tc_div_clr)
    else $error("divider clear pulse missing");
  a_div_clr_cause: assert property (o_tc_div_clr |->
    $past(wr_ctl && i_reg.wdata[DIV_CLR_BIT]))
    else $error("divider clear without write");
  a_cnt_clr_quiet: assert property (wr_ctl &&
    i_reg.wdata[CNT_CLR_BIT] |=> !o_basic_overflow_pulse [*8])
    else $error("wrap right after clear");
  a_wdt_on_wrap: assert property (o_wdt_reset &&
    !i_opt_ring_src |-> o_basic_overflow_pulse)
    else $error("reset not on a wrap");
  a_wdt_disabled: assert property (o_wdt_reset |->
    $past(bkey_ff) != KEY_CODE)
    else $error("reset while disabled");
  a_wdt_kick_quiet: assert property (s_kick |=> !o_wdt_reset [*8])
    else $error("reset right after kick");
  a_hold_short: assert property ($rose(i_rst_n) &&
    !i_power_on |=> !o_cpu_hold)
    else $error("hold kept without power-on");
  a_hold_long: assert property ($rose(i_rst_n) &&
    i_power_on |=> o_cpu_hold)
    else $error("hold lost after power-on");
  a_ring_stop: assert property (i_opt_ring_src &&
    wkey_ff == KEY_CODE && i_stop_idle |=> !o_ring_osc_en)
    else $error("ring kept running");
  a_unmapped_zero: assert property (rd_bad |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind basic_timer_watchdog basic_timer_watchdog_chk u_chk (.*);

// ==== dv/tb_basic_timer_watchdog.sv ====
`timescale 1ns/10ps
module tb_basic_timer_watchdog import bt_wdt_pkg::*;;
  // ****
  // Stimulus and results
  // ****
  logic i_sys_clk = 1'b0; // 100 ns period.
  logic i_rst_n = 1'b0; // Held low at start.
  reg_req_s i_reg = '0; // Register request.
  logic ring = 1'b0; // Ring source option.
  logic tick = 1'b0; // Ring tick, held high: one per cycle.
  logic stop = 1'b0; // Stop or idle.
  logic pwr = 1'b0; // Power-on flag of the last reset.
  logic [7:0] rdata; // Read data.
  logic wdt_rst, hold, tc_clr, osc_en, ovf; // Flags.
  int failures = 0;
  int n_compared = 0;
  int n_rst = 0; // Reset requests seen.
  int n;
  int div[4] = '{4096, 1024, 128, 16};
  always #50 i_sys_clk = ~i_sys_clk;
  basic_timer_watchdog uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_reg(i_reg), .i_power_on(pwr), .i_opt_ring_src(ring),
    .i_ring_tick(tick), .i_stop_idle(stop), .o_reg_rdata(rdata),
    .o_wdt_reset(wdt_rst), .o_cpu_hold(hold), .o_tc_div_clr(tc_clr),
    .o_ring_osc_en(osc_en), .o_basic_overflow_pulse(ovf));
  // Counted mid-cycle so the edge update has landed.
  always @(negedge i_sys_clk) if (wdt_rst === 1'b1) n_rst++;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) i_reg <= {1'b1, 1'b0, a, d};
    @(posedge i_sys_clk) i_reg <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk) i_reg <= {1'b0, 1'b1, a, 8'h00};
    @(posedge i_sys_clk) i_reg <= '0;
    #1 chk(rdata, e);
  endtask
  // Edges until a pulse (0 wrap, 1 reset); the bound stops a hang.
  task automatic gap(input bit which, output int k);
    k = 0;
    do begin
      @(posedge i_sys_clk);
      #1 k++;
    end while ((which ? wdt_rst : ovf) !== 1'b1 && k < 70000);
  endtask
  task automatic finish_test;
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Clean path is about 90100 cycles; a hang is caught at 97000.
  initial begin
    #(100 * 97000);
    failures++;
    finish_test();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_BASIC_TIMER_CONTROL, CTRL_RESET);
    chk(hold, 1'b0);
    rd(8'h10, 8'h00);
    // Each ratio: read mid-way through the fourth tick period.
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_BASIC_TIMER_CONTROL, {KEY_CODE, s[1:0], 2'h3});
      #1 chk(tc_clr, 1'b1);
      wr(ADDR_BASIC_TIMER_COUNT, 8'h55);
      repeat (div[s] * 7 / 2 - 3) @(posedge i_sys_clk);
      rd(ADDR_BASIC_TIMER_COUNT, 8'h03);
    end
    rd(ADDR_BASIC_TIMER_CONTROL, 8'hAC);
    wr(ADDR_BASIC_TIMER_CONTROL, 8'hAF);
    gap(1'b0, n);
    chk(n, 4096);
    @(posedge i_sys_clk) ring <= 1'b1;
    tick <= 1'b1;
    wr(ADDR_BASIC_TIMER_CONTROL, 8'h0C);
    wr(ADDR_WATCHDOG_CONTROL, 8'h0A);
    gap(1'b1, n);
    chk(n, 256);
    wr(ADDR_WATCHDOG_CONTROL, 8'hAA);
    n = n_rst;
    repeat (3) begin
      repeat (200) @(posedge i_sys_clk);
      wr(ADDR_WATCHDOG_CONTROL, 8'hAA);
    end
    chk(n_rst - n, 0);
    rd(ADDR_WATCHDOG_CONTROL, 8'hA0);
    @(posedge i_sys_clk) stop <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 chk(osc_en, 1'b0);
    @(posedge i_sys_clk) stop <= 1'b0;
    wr(ADDR_BASIC_TIMER_CONTROL, 8'hAC);
    n = n_rst;
    repeat (600) @(posedge i_sys_clk);
    chk(n_rst - n, 0);
    @(posedge i_sys_clk) ring <= 1'b0;
    wr(ADDR_BASIC_TIMER_CONTROL, 8'h0F);
    gap(1'b1, n);
    chk(n, 65536);
    // Second reset, a power-on one: the hold lasts 32 ticks; the fast
    // ratio written during the hold keeps that to 512 cycles.
    @(posedge i_sys_clk) i_rst_n <= 1'b0;
    pwr <= 1'b1;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wr(ADDR_BASIC_TIMER_CONTROL, 8'hAF);
    repeat (511) @(posedge i_sys_clk);
    #1 chk(hold, 1'b1);
    @(posedge i_sys_clk);
    #1 chk(hold, 1'b0);
    finish_test();
  end
endmodule
